// ===== dv/rcs_monitor.sv
// Assertion checker for the reset and clock select block
module rcs_monitor #(
    parameter int HOLD_CYC = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire rcs_pkg::rcs_cause_s cause,
    input wire logic [8:0] src_en,
    input wire logic [6:0] trim_in,
    input wire rcs_pkg::rcs_clk_cfg_s clk_cfg,
    input wire logic sys_reset,
    input wire logic wdog_locked,
    input wire logic [6:0] osc_trim,
    input wire logic [2:0] xo_mode,
    input wire logic [1:0] sys_clk_sel,
    input wire logic [1:0] usb_clk_sel,
    input wire logic mult_src_ext
);
    timeunit 1ns;
    timeprecision 100ps;
    import rcs_pkg::*;
    // Length of the current reset pulse in cycles
    int high_cnt;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    always_ff @(posedge mclk) begin
        if (rst) high_cnt <= 0;
        else if (sys_reset) high_cnt <= high_cnt + 1;
        else high_cnt <= 0;
    end
    sequence s_hit;
        cause.por || cause.pin || cause.flash_err || (cause.supply_low && src_en[1]);
    endsequence
    sequence s_wd_lock;
        wdog_locked && cause.watchdog_timer;
    endsequence
    AST_HIT: assert property (s_hit |=> sys_reset)
        else $error("reset cause not answered");
    AST_HOLD: assert property ($fell(sys_reset) |-> high_cnt >= HOLD_CYC + 2)
        else $error("reset released too soon");
    AST_LOCK: assert property (s_wd_lock |=> sys_reset)
        else $error("locked watchdog ignored");
    AST_LOCK_STAY: assert property (wdog_locked && !cause.por |=> wdog_locked)
        else $error("watchdog lock lost");
    AST_TRIM: assert property (1'b1 |=> osc_trim == $past(trim_in))
        else $error("trim not applied");
    AST_SYS: assert property (1'b1 |=> sys_clk_sel == $past(clk_cfg.sys_sel))
        else $error("system clock select wrong");
    AST_XO: assert property (1'b1 |=> xo_mode == $past(clk_cfg.xo_mode))
        else $error("oscillator mode wrong");
    AST_MSRC: assert property (1'b1 |=> mult_src_ext == $past(clk_cfg.mult_src_ext))
        else $error("multiplier source wrong");
    AST_USB_LS: assert property (clk_cfg.usb_low_speed |=> usb_clk_sel == 2'h1)
        else $error("low speed usb clock wrong");
endmodule // rcs_monitor
bind rcs_top rcs_monitor #(.HOLD_CYC(HOLD_CYC)) mon_u (
    .mclk(mclk),
    .rst(rst),
    .cause(cause),
    .src_en(src_en),
    .trim_in(trim_in),
    .clk_cfg(clk_cfg),
    .sys_reset(sys_reset),
    .wdog_locked(wdog_locked),
    .osc_trim(osc_trim),
    .xo_mode(xo_mode),
    .sys_clk_sel(sys_clk_sel),
    .usb_clk_sel(usb_clk_sel),
    .mult_src_ext(mult_src_ext)
);

// ===== dv/rcs_src_model.sv
// Model of the reset-causing monitors
module rcs_src_model (
    input wire logic mclk,
    output rcs_pkg::rcs_cause_s cause
);
    timeunit 1ns;
    timeprecision 100ps;
    import rcs_pkg::*;
    initial cause = '0;
    // Source index to cause bit, held two edges
    task automatic fire(input int s);
        logic [9:0] m;
        m = (s == 0) ? 10'h200 : 10'h100 >> (s > 2 ? s : s - 1);
        @(posedge mclk) #1 cause = cause | m;
        repeat (2) @(posedge mclk);
        #1 cause = cause & ~m;
    endtask
    task automatic vbus();
        @(posedge mclk) #1 cause.usb_vbus = !cause.usb_vbus;
    endtask
endmodule // rcs_src_model

// ===== dv/test_rcs_top.sv
// Self-checking bench for the reset and clock select block
module test_rcs_top;
    timeunit 1ns;
    timeprecision 100ps;
    import rcs_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    rcs_cause_s cause;
    logic [8:0] src_en = 9'h1ff;
    logic wdog_lock_req = 1'b0;
    logic [6:0] trim_in = 7'h40;
    rcs_clk_cfg_s clk_cfg = '0;
    logic sys_reset, wdog_locked, mult_src_ext, mult_en;
    logic [8:0] last_cause;
    logic [6:0] osc_trim;
    logic [2:0] xo_mode;
    logic [1:0] sys_clk_sel, usb_clk_sel;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    always #12.5 mclk = ~mclk;
    rcs_top dut_u (
        .mclk(mclk),
        .rst(rst),
        .cause(cause),
        .src_en(src_en),
        .wdog_lock_req(wdog_lock_req),
        .trim_in(trim_in),
        .clk_cfg(clk_cfg),
        .sys_reset(sys_reset),
        .last_cause(last_cause),
        .wdog_locked(wdog_locked),
        .osc_trim(osc_trim),
        .xo_mode(xo_mode),
        .sys_clk_sel(sys_clk_sel),
        .usb_clk_sel(usb_clk_sel),
        .mult_src_ext(mult_src_ext),
        .mult_en(mult_en)
    );
    rcs_src_model src_u (.mclk, .cause);
    task automatic cmp(input string nm, input logic [8:0] e, input logic [8:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wait_rel();
        int n;
        n = 0;
        while (sys_reset !== 1'b0 && n < 20) begin
            tick(1);
            n++;
        end
    endtask
    task automatic hit(input int s, input logic e);
        src_u.fire(s);
        cmp("sys_reset", {8'h0, e}, {8'h0, sys_reset});
        wait_rel();
        if (e) cmp("last_cause", 9'h1 << s, last_cause);
    endtask
    task automatic t_src();
        for (int s = 0; s < 9; s++) hit(s, 1'b1);
    endtask
    task automatic t_mask();
        src_en = 9'h000;
        for (int s = 0; s < 9; s++) hit(s, s == 0 || s > 6);
        src_u.vbus();
        tick(3);
        cmp("vbus_masked", 9'h0, {8'h0, sys_reset});
    endtask
    task automatic t_vbus();
        src_en = 9'h004;
        src_u.vbus();
        tick(3);
        cmp("vbus_reset", 9'h1, {8'h0, sys_reset});
        wait_rel();
        cmp("vbus_cause", 9'h004, last_cause);
    endtask
    task automatic t_lock();
        src_en = 9'h000;
        wdog_lock_req = 1'b1;
        tick(1);
        wdog_lock_req = 1'b0;
        tick(1);
        cmp("wdog_locked", 9'h1, {8'h0, wdog_locked});
        hit(3, 1'b1);
        hit(0, 1'b1);
        cmp("wdog_unlock", 9'h0, {8'h0, wdog_locked});
        hit(3, 1'b0);
    endtask
    task automatic t_clk();
        clk_cfg.usb_low_speed = 1'b1;
        for (int i = 0; i < 7; i++) begin
            clk_cfg.sys_sel = rcs_sys_e'(i % 3);
            clk_cfg.xo_mode = rcs_xo_e'(i);
            clk_cfg.mult_src_ext = i[0];
            trim_in = 7'(i * 21 + 1);
            tick(2);
            cmp("sys_clk_sel", 9'(i % 3), {7'h0, sys_clk_sel});
            cmp("xo_mode", 9'(i), {6'h0, xo_mode});
            cmp("mult_src_ext", 9'(i % 2), {8'h0, mult_src_ext});
            cmp("osc_trim", 9'(i * 21 + 1), {2'h0, osc_trim});
            cmp("usb_ls", 9'h1, {7'h0, usb_clk_sel});
        end
        clk_cfg = '{RCS_SYS_INT, 1'b0, 1'b0, 1'b1, 1'b1, RCS_XO_OFF};
        tick(2);
        cmp("usb_fs", 9'h2, {7'h0, usb_clk_sel});
        cmp("mult_en", 9'h1, {8'h0, mult_en});
        clk_cfg.recovery_en = 1'b0;
        tick(2);
        cmp("usb_off", 9'h0, {7'h0, usb_clk_sel});
        clk_cfg.mult_src_ext = 1'b1;
        tick(2);
        cmp("usb_ext", 9'h2, {7'h0, usb_clk_sel});
    endtask
    initial begin
        tick(8);
        rst = 1'b0;
        wait_rel();
        cmp("rst_release", 9'h0, {8'h0, sys_reset});
        cmp("rst_cause", 9'h001, last_cause);
        t_src();
        t_mask();
        t_vbus();
        t_lock();
        t_clk();
        stop_test();
    end
endmodule // test_rcs_top

// ===== hw/rcs_clk_sel.sv
// Registered clock source selection
`include "rcs_regs.svh"
module rcs_clk_sel (
    input wire logic mclk,
    input wire logic rst,
    input wire rcs_pkg::rcs_clk_cfg_s cfg,
    output logic [1:0] sys_sel,
    output logic [1:0] usb_sel,
    output logic mult_src
);
    import rcs_pkg::*;
    // System select follows cfg alone
    always_ff @(posedge mclk) begin
        if (rst) sys_sel <= RCS_SYS_INT;
        else sys_sel <= cfg.sys_sel;
    end
    // 0 none, 1 internal direct, 2 multiplier
    always_ff @(posedge mclk) begin
        if (rst) begin
            usb_sel <= 2'h0;
            mult_src <= 1'b0;
        end else begin
            mult_src <= cfg.mult_src_ext;
            if (cfg.usb_low_speed) usb_sel <= 2'h1;
            else if (cfg.mult_en && (cfg.mult_src_ext || cfg.recovery_en)) begin
                usb_sel <= 2'h2;
            end else usb_sel <= 2'h0;
        end
    end
endmodule // rcs_clk_sel

// ===== hw/rcs_edge.sv
// Change detector on a single level
module rcs_edge (
    input wire logic mclk,
    input wire logic rst,
    input wire logic level,
    output logic change
);
    logic prev_reg;
    logic seen_reg;
    always_ff @(posedge mclk) begin
        if (rst) begin
            prev_reg <= 1'b0;
            seen_reg <= 1'b0;
        end else begin
            prev_reg <= level;
            seen_reg <= 1'b1;
        end
    end
    // First sample only primes the history
    assign change = seen_reg & (prev_reg ^ level);
endmodule // rcs_edge

// ===== hw/rcs_top.sv
// Reset gathering and clock source control
// Operation
// - Nine reset causes combine into one system reset.
// - Supply below threshold forces reset.
// - USB bus reset or bus supply change forces reset.
// - Each source is maskable except power-on, pin and flash error.
// - After power-on, software may lock the watchdog enabled.
// - Trim value adjusts internal oscillator period in quarter percent steps.
// - System clock picks internal, external or multiplier halved.
// - System clock source may change while running.
// - Full speed USB clock is the multiplier output, fed by the recovered internal oscillator or the external oscillator.
// - Low speed USB clock is internal oscillator directly.
// - Multiplier may take external oscillator as input.
// - System and USB clock selections are independent.
// - External oscillator drive supports crystal, resonator, C, RC, CMOS.
`include "rcs_regs.svh"
module rcs_top #(
    parameter int HOLD_CYC = `RCS_HOLD_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire rcs_pkg::rcs_cause_s cause,
    input wire logic [8:0] src_en,
    input wire logic wdog_lock_req,
    input wire logic [`RCS_TRIM_W-1:0] trim_in,
    input wire rcs_pkg::rcs_clk_cfg_s clk_cfg,
    output logic sys_reset,
    output logic [8:0] last_cause,
    output logic wdog_locked,
    output logic [`RCS_TRIM_W-1:0] osc_trim,
    output logic [2:0] xo_mode,
    output logic [1:0] sys_clk_sel,
    output logic [1:0] usb_clk_sel,
    output logic mult_src_ext,
    output logic mult_en
);
    import rcs_pkg::*;
    rcs_rs_e state_reg;
    logic [8:0] req;
    logic [8:0] en_eff;
    logic [8:0] capt_reg;
    logic vbus_change;
    logic [15:0] hold_reg;
    logic por_seen_reg;
    logic [1:0] sys_sel_w;
    logic [1:0] usb_sel_w;
    logic mult_src_w;

    rcs_edge u_vbus (
        .mclk(mclk),
        .rst(rst),
        .level(cause.usb_vbus),
        .change(vbus_change)
    );

    // Locked watchdog cannot be masked
    always_comb begin
        en_eff = src_en | `RCS_ALWAYS_ON;
        if (wdog_locked) en_eff[`RCS_SRC_WDOG] = 1'b1;
    end

    always_comb begin
        req = '0;
        req[`RCS_SRC_POR] = cause.por;
        req[`RCS_SRC_SUPPLY] = cause.supply_low;
        req[`RCS_SRC_USB] = cause.usb_bus_reset | vbus_change;
        req[`RCS_SRC_WDOG] = cause.watchdog_timer;
        req[`RCS_SRC_MCLK] = cause.missing_clock;
        req[`RCS_SRC_CMP] = cause.first_comparator;
        req[`RCS_SRC_SOFT] = cause.soft_req;
        req[`RCS_SRC_PIN] = cause.pin;
        req[`RCS_SRC_FLASH] = cause.flash_err;
        req = req & en_eff;
    end

    // Reset sequencer with minimum hold
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= RCS_RS_RESET;
            hold_reg <= '0;
        end else begin
            unique case (state_reg)
                RCS_RS_RUN: begin
                    if (|req) state_reg <= RCS_RS_RESET;
                end
                RCS_RS_RESET: begin
                    hold_reg <= '0;
                    if (!(|req)) state_reg <= RCS_RS_HOLD;
                end
                RCS_RS_HOLD: begin
                    if (|req) state_reg <= RCS_RS_RESET;
                    else if (hold_reg >= 16'(HOLD_CYC - 1)) state_reg <= RCS_RS_RUN;
                    else hold_reg <= hold_reg + 16'h0001;
                end
                default: state_reg <= RCS_RS_RESET;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) sys_reset <= 1'b1;
        else sys_reset <= (state_reg != RCS_RS_RUN) || (|req);
    end

    // Causes gather during reset, published on release
    always_ff @(posedge mclk) begin
        if (rst) begin
            capt_reg <= 9'h001;
            last_cause <= 9'h001;
        end else if (state_reg == RCS_RS_RUN) begin
            capt_reg <= req;
        end else begin
            capt_reg <= capt_reg | req;
            if (state_reg == RCS_RS_HOLD && !(|req) && hold_reg >= 16'(HOLD_CYC - 1)) begin
                last_cause <= capt_reg;
            end
        end
    end

    // Lock only after power-on; cleared only by power-on
    always_ff @(posedge mclk) begin
        if (rst) begin
            por_seen_reg <= 1'b1;
            wdog_locked <= 1'b0;
        end else if (cause.por) begin
            por_seen_reg <= 1'b1;
            wdog_locked <= 1'b0;
        end else if (wdog_lock_req && por_seen_reg) begin
            wdog_locked <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) osc_trim <= `RCS_TRIM_RST;
        else osc_trim <= trim_in;
    end

    always_ff @(posedge mclk) begin
        if (rst) xo_mode <= RCS_XO_OFF;
        else xo_mode <= clk_cfg.xo_mode;
    end

    rcs_clk_sel u_sel (
        .mclk(mclk),
        .rst(rst),
        .cfg(clk_cfg),
        .sys_sel(sys_sel_w),
        .usb_sel(usb_sel_w),
        .mult_src(mult_src_w)
    );

    assign sys_clk_sel = sys_sel_w;
    assign usb_clk_sel = usb_sel_w;
    assign mult_src_ext = mult_src_w;

    always_ff @(posedge mclk) begin
        if (rst) mult_en <= 1'b0;
        else mult_en <= clk_cfg.mult_en;
    end
endmodule // rcs_top

// ===== shared/rcs_pkg.sv
// Types for the reset and clock select block
package rcs_pkg;
    typedef enum logic [1:0] {
        RCS_SYS_INT = 2'h0,
        RCS_SYS_EXT = 2'h1,
        RCS_SYS_MULT = 2'h2
    } rcs_sys_e;
    typedef enum logic [2:0] {
        RCS_XO_OFF = 3'h0,
        RCS_XO_CMOS = 3'h1,
        RCS_XO_CMOS_DIV = 3'h2,
        RCS_XO_RC = 3'h3,
        RCS_XO_CAP = 3'h4,
        RCS_XO_CRYSTAL = 3'h5,
        RCS_XO_RESONATOR = 3'h6
    } rcs_xo_e;
    typedef enum logic [1:0] {
        RCS_RS_RUN = 2'h0,
        RCS_RS_RESET = 2'h1,
        RCS_RS_HOLD = 2'h3
    } rcs_rs_e;
    typedef struct packed {
        logic por;
        logic supply_low;
        logic usb_bus_reset;
        logic usb_vbus;
        logic watchdog_timer;
        logic missing_clock;
        logic first_comparator;
        logic soft_req;
        logic pin;
        logic flash_err;
    } rcs_cause_s;
    typedef struct packed {
        rcs_sys_e sys_sel;
        logic usb_low_speed;
        logic mult_src_ext;
        logic mult_en;
        logic recovery_en;
        rcs_xo_e xo_mode;
    } rcs_clk_cfg_s;
endpackage

// ===== shared/rcs_regs.svh
// Constants for the reset and clock select block
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH
`define RCS_NSRC 9
`define RCS_SRC_POR 0
`define RCS_SRC_SUPPLY 1
`define RCS_SRC_USB 2
`define RCS_SRC_WDOG 3
`define RCS_SRC_MCLK 4
`define RCS_SRC_CMP 5
`define RCS_SRC_SOFT 6
`define RCS_SRC_PIN 7
`define RCS_SRC_FLASH 8
`define RCS_ALWAYS_ON 9'h181
`define RCS_EN_RST 9'h000
`define RCS_TRIM_W 7
`define RCS_TRIM_RST 7'h40
`define RCS_MULT 4
`define RCS_HOLD_NS 100
`define RCS_CLK_NS 25
`define RCS_HOLD_CYC ((`RCS_HOLD_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS)
`endif
